//--- rtl/opvi_pkg.sv
// Constants and types for the one-pin voltage interface decoder.
// Assumes a 10 MHz core clock and a host that idles the pin high or low.
package opvi_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int TIMEOUT_US      = 520;
  localparam int TIMEOUT_CYC     = (TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int ACK_US          = 520;
  localparam int ACK_CYC         = (ACK_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W           = 13;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS      = 16;
  localparam int ACK_REQ_POS     = 7;
  localparam int SEL_HI_POS      = 6;
  localparam int SEL_LO_POS      = 5;
  localparam logic [1:0] SEL_CONV1 = 2'h0;
  localparam logic [1:0] SEL_CONV2 = 2'h2;
  localparam logic [4:0] VSEL_RESET = 5'h00;
  localparam logic [4:0] VSEL_EXTERNAL = 5'h00;
  // Mode output encoding
  typedef enum logic {OPVI_PWR_SAVE, OPVI_FORCED_PWM} opvi_mode_t;
  typedef struct packed {
    logic       ack_request_bit;
    logic [1:0] reg_select;
    logic [4:0] value;
  } opvi_data_t;
endpackage

//--- rtl/opvi_bit_timer.sv
// Low/high phase timer classifying one bit between falling edges.
// Assumes pin input synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module opvi_bit_timer #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  // Control
  input  wire logic         i_clear,
  input  wire logic         i_pin,
  // Results
  output logic [W-1:0]      o_low,
  output logic [W-1:0]      o_high,
  output logic              o_bit,
  output logic              o_valid
);
  logic [W-1:0] low_q, low_d, high_q, high_d;
  always_comb begin
    low_d  = low_q;
    high_d = high_q;
    if (i_clear) begin
      low_d  = '0;
      high_d = '0;
    end else if (!i_pin && low_q != '1) begin
      low_d = low_q + W'(1);
    end else if (i_pin && high_q != '1) begin
      high_d = high_q + W'(1);
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      low_q  <= '0;
      high_q <= '0;
    end else begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end
  assign o_low   = low_q;
  assign o_high  = high_q;
  // Ratio test on the finished bit
  assign o_bit   = ({1'b0, high_q} >= {low_q, 1'b0});
  assign o_valid = ({1'b0, high_q} >= {low_q, 1'b0}) || ({1'b0, low_q} >= {high_q, 1'b0});
endmodule
`default_nettype wire

//--- rtl/opvi_decoder.sv
// One-pin serial decoder with mode selection and acknowledge driver.
// Assumes pin sampled synchronously; a pull-up holds the line high and the host pulls it low.
`timescale 1ns/10ps
`default_nettype none
module opvi_decoder #(
  parameter int          TIMEOUT_CYC = opvi_pkg::TIMEOUT_CYC,
  parameter int          ACK_CYC     = opvi_pkg::ACK_CYC,
  parameter logic [7:0]  DEV_ADDR    = 8'hA5  // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Shared mode/data pin
  input  wire logic        i_pin,
  output logic             o_pin_out,
  output logic             o_pin_oe,
  // Mode and registers
  output logic             o_forced_pwm,
  output logic [4:0]       o_converter1_voltage_select,
  output logic [4:0]       o_converter2_voltage_select,
  output logic             o_conv1_external_fb,
  output logic             o_frame_busy
);
  localparam int W = opvi_pkg::CNT_W;
  typedef enum {S_IDLE, S_LOW, S_HIGH, S_ACK} opvi_state_t;

  opvi_state_t  st_q, st_d;
  logic         pin_q;
  logic [15:0]  sh_q, sh_d;
  logic [4:0]   nbit_q, nbit_d;
  logic         bad_q, bad_d;
  logic         pwm_q, pwm_d;
  logic         skip_q, skip_d;
  logic [W-1:0] ack_q, ack_d;
  logic [4:0]   v1_q, v1_d, v2_q, v2_d;
  logic         oe_q, oe_d;
  logic         clr;
  logic [W-1:0] bit_low_time, bit_high_time;
  logic         bitv, bitok;
  logic         fall;
  opvi_pkg::opvi_data_t dat;

  assign fall = pin_q && !i_pin;
  assign dat  = sh_q[7:0];

  opvi_bit_timer #(.W(W)) u_tmr (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_clear(clr),
    .i_pin  (i_pin),
    .o_low  (bit_low_time),
    .o_high (bit_high_time),
    .o_bit  (bitv),
    .o_valid(bitok)
  );

  // ----------------------------------------
  // Frame state machine
  // ----------------------------------------
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    nbit_d = nbit_q;
    bad_d  = bad_q;
    pwm_d  = pwm_q;
    skip_d = skip_q;
    ack_d  = ack_q;
    v1_d   = v1_q;
    v2_d   = v2_q;
    oe_d   = 1'b0;
    clr    = 1'b0;
    if (i_pin && st_q != S_ACK) pwm_d = 1'b1;
    case (st_q)
      S_IDLE: begin
        if (fall) begin
          clr    = 1'b1;
          nbit_d = '0;
          bad_d  = 1'b0;
          skip_d = 1'b1;
          st_d   = S_LOW;
        end
      end
      S_LOW, S_HIGH: begin
        if (st_q == S_LOW && i_pin) st_d = S_HIGH;
        if (!i_pin && {{(32-W){1'b0}}, bit_low_time} >= TIMEOUT_CYC - 1) begin
          pwm_d = 1'b0;
          st_d  = S_IDLE;
        end else if (fall) begin
          clr = 1'b1;
          if (skip_q) begin
            skip_d = 1'b0;
          end else begin
            sh_d   = {sh_q[14:0], bitv};
            nbit_d = nbit_q + 5'h01;
            bad_d  = bad_q | ~bitok;
          end
          st_d = S_LOW;
        end
        if (fall && !skip_q && nbit_q == 5'(opvi_pkg::FRAME_BITS - 1)) begin
          st_d = S_IDLE;
          if (!bad_d && sh_d[15:8] == DEV_ADDR) begin
            if (sh_d[6:5] == opvi_pkg::SEL_CONV1) v1_d = sh_d[4:0];
            if (sh_d[6:5] == opvi_pkg::SEL_CONV2) v2_d = sh_d[4:0];
            if (sh_d[opvi_pkg::ACK_REQ_POS]) begin
              st_d  = S_ACK;
              ack_d = '0;
            end
          end
        end
      end
      S_ACK: begin
        oe_d  = 1'b1;
        ack_d = ack_q + W'(1);
        if ({{(32-W){1'b0}}, ack_q} >= ACK_CYC - 2) begin
          oe_d = 1'b0;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (st_q != S_IDLE && st_q != S_ACK && st_d != S_IDLE) pwm_d = 1'b1;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q   <= S_IDLE;
      pin_q  <= 1'b1;
      sh_q   <= '0;
      nbit_q <= '0;
      bad_q  <= 1'b0;
      pwm_q  <= 1'b0;
      skip_q <= 1'b0;
      ack_q  <= '0;
      v1_q   <= opvi_pkg::VSEL_RESET;
      v2_q   <= opvi_pkg::VSEL_RESET;
      oe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      pin_q  <= i_pin;
      sh_q   <= sh_d;
      nbit_q <= nbit_d;
      bad_q  <= bad_d;
      pwm_q  <= pwm_d;
      skip_q <= skip_d;
      ack_q  <= ack_d;
      v1_q   <= v1_d;
      v2_q   <= v2_d;
      oe_q   <= oe_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic busy_q;
  logic ext_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      ext_q  <= 1'b1;
    end else begin
      busy_q <= (st_d == S_LOW || st_d == S_HIGH);
      ext_q  <= (v1_d == opvi_pkg::VSEL_EXTERNAL);
    end
  end
  assign o_pin_out                   = 1'b0;
  assign o_pin_oe                    = oe_q;
  assign o_forced_pwm                = pwm_q;
  assign o_converter1_voltage_select = v1_q;
  assign o_converter2_voltage_select = v2_q;
  assign o_conv1_external_fb         = ext_q;
  assign o_frame_busy                = busy_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_high_forces_pwm: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_pin && !oe_q) |=> o_forced_pwm) else $error("pin high did not force pwm");
  a_busy_keeps_pwm: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_frame_busy |-> o_forced_pwm) else $error("pwm dropped during frame");
  a_ack_only_oe: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_pin_oe |-> (o_pin_out == 1'b0 && st_q == S_ACK)) else $error("bad ack drive");
  a_ack_req_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_pin_oe) |-> sh_q[15:8] == DEV_ADDR && sh_q[opvi_pkg::ACK_REQ_POS])
    else $error("ack without request or match");
  a_save_on_low: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(o_forced_pwm) |-> !i_pin) else $error("power save with pin high");
  a_v1_stable: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == S_IDLE && !fall) |=> $stable(v1_q)) else $error("register changed idle");
  a_fall_starts: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == S_IDLE && fall) |=> st_q == S_LOW) else $error("fall did not start bit");
  a_sel_conv2: assert property (@(posedge i_mclk) disable iff (i_rst)
    $changed(v2_q) |-> $past(sh_d[6:5]) == opvi_pkg::SEL_CONV2) else $error("wrong target");

  // ----------------------------------------
  // Timeout, acknowledge and output checks
  // ----------------------------------------
  a_timeout_save: assert property (@(posedge i_mclk) disable iff (i_rst)
    ((st_q == S_LOW || st_q == S_HIGH) && !i_pin && bit_low_time >= W'(TIMEOUT_CYC - 1)) |=> !o_forced_pwm)
    else $error("timeout did not enable power save");
  a_ack_clean: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_pin_oe) |-> !bad_q) else $error("ack after bad bit");
  a_ack_ends: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(o_pin_oe) |-> st_q == S_IDLE) else $error("ack end left wrong state");
  a_idle_no_oe: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == S_IDLE) |-> !o_pin_oe) else $error("pin driven while idle");
  a_ext_follows: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_conv1_external_fb == (o_converter1_voltage_select == opvi_pkg::VSEL_EXTERNAL))
    else $error("external feedback flag wrong");
  a_busy_on_fall: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == S_IDLE && fall) |=> o_frame_busy) else $error("busy not raised");
  a_sel_conv1: assert property (@(posedge i_mclk) disable iff (i_rst)
    $changed(v1_q) |-> $past(sh_d[6:5]) == opvi_pkg::SEL_CONV1) else $error("wrong target one");
endmodule
`default_nettype wire

//--- dv/opvi_host_model.sv
// Host model driving the shared mode/data pin through an open-drain stage.
// Assumes a pull-up on the wire and the device's acknowledge driver beside it.
`timescale 1ns/10ps
`default_nettype none
module opvi_host_model (
  // Clock
  input  wire logic i_mclk,
  // Open-drain pull-down, so the device's acknowledge can also pull the wire low
  output logic      o_pull_low
);
  initial o_pull_low = 1'b0;
  // ----------------------------------------
  // Pin phases
  // ----------------------------------------
  task automatic drive(input logic lv, input int n);
    o_pull_low <= ~lv;
    repeat (n) @(posedge i_mclk);
  endtask
  // Bit from fall to fall; a bad bit has equal phases
  task automatic bit_out(input logic b, input logic bad);
    drive(1'b0, bad ? 5 : (b ? 2 : 8));
    drive(1'b1, bad ? 5 : (b ? 8 : 2));
  endtask
  // Leading start bit, address then data, closing fall held low
  task automatic send(input logic [15:0] f, input int bad_pos);
    bit_out(1'b1, 1'b0);
    for (int i = 15; i >= 0; i--) bit_out(f[i], i == bad_pos);
    drive(1'b0, 3);
    drive(1'b1, 1);
  endtask
endmodule
`default_nettype wire

//--- dv/test_one_pin_voltage_interface.sv
// Testbench for the one-pin voltage interface decoder.
// Assumes the host model and a pull-up on the shared wire.
`timescale 1ns/10ps
`default_nettype none
module test_one_pin_voltage_interface;
  localparam int         TO   = 200;
  localparam logic [7:0] ADDR = 8'h3A; // Arbitrary identity value
  logic       i_mclk;
  logic       i_rst;
  logic       host_low;
  logic       pin_w;
  logic       oe;
  logic       pout;
  logic       pwm;
  logic       ext;
  logic       busy;
  logic [4:0] v1;
  logic [4:0] v2;
  int         fail_count;
  int         cmp_count;
  logic [15:0] fr [8] = '{16'h3A83, 16'h3A4C, 16'h5C9F, 16'h3ABF, 16'h3AFF, 16'h3A9F, 16'h3A80, 16'h3A9F};
  int          badp [8] = '{-1, -1, -1, -1, -1, 2, -1, -1};
  logic [10:0] ex [8] = '{11'h460, 11'h06C, 11'h06C, 11'h46C, 11'h46C, 11'h06C, 11'h40C, 11'h7EC};
  // ----------------------------------------
  // Wire and instances
  // ----------------------------------------
  assign pin_w = ~(host_low | (oe & ~pout));
  opvi_decoder #(.TIMEOUT_CYC(TO), .ACK_CYC(TO), .DEV_ADDR(ADDR)) uut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_pin(pin_w), .o_pin_out(pout), .o_pin_oe(oe),
    .o_forced_pwm(pwm), .o_converter1_voltage_select(v1), .o_converter2_voltage_select(v2),
    .o_conv1_external_fb(ext), .o_frame_busy(busy));
  opvi_host_model host (.i_mclk(i_mclk), .o_pull_low(host_low));
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    print_verdict();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    fail_count = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_mclk);
    #1 chk({4'h0, pwm, oe, busy, ext}, 8'h01, "reset state");
    chk({3'h0, v1 | v2}, 8'h00, "reset codes");
    @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 chk({7'h0, pwm}, 8'h01, "pin high mode");
    @(posedge i_mclk);
    for (int k = 0; k < 8; k++) begin
      fork
        host.send(fr[k], badp[k]);
        begin
          repeat (100) @(posedge i_mclk);
          #1 chk({6'h0, busy, pwm}, 8'h03, "frame busy");
        end
      join
      #1 chk({7'h0, oe}, {7'h0, ex[k][10]}, "ack drive");
      chk({7'h0, pin_w}, {7'h0, ~ex[k][10]}, "ack wire");
      for (int i = 0; i < 300 && oe !== 1'b0; i++) @(posedge i_mclk);
      repeat (4) @(posedge i_mclk);
      #1 chk({3'h0, v1}, {3'h0, ex[k][9:5]}, "conv1");
      chk({3'h0, v2}, {3'h0, ex[k][4:0]}, "conv2");
      chk({7'h0, ext}, {7'h0, ex[k][9:5] == 5'h00}, "ext fb");
      @(posedge i_mclk);
    end
    host.drive(1'b0, TO - 20);
    #1 chk({7'h0, pwm}, 8'h01, "early save");
    repeat (30) @(posedge i_mclk);
    #1 chk({7'h0, pwm}, 8'h00, "power save");
    @(posedge i_mclk);
    host.drive(1'b1, 3);
    #1 chk({7'h0, pwm}, 8'h01, "forced mode");
    print_verdict();
  end
endmodule
`default_nettype wire
